// *** rtl/csi2_tx_timing_defs.vh ***
// How it works
// [RL1] Reg 4h bit7 high uses bits[4:0] as prepare timing, else automatic.
// [RL2] Reg 5h bit7 high uses bits[4:0] as zero timing, else automatic.
// [RL3] Reg 6h bit7 high uses bits[3:0] as trail timing, else automatic.
// [RL4] Reg 7h bit7 high uses bits[4:0] as exit timing, else automatic.
// [RL5] Reg 8h bit7 high uses bits[3:0] as low-power period, else automatic.
// [RL6] Reg 9h bit4 puts raw pixels on low bits (0) or high bits (1).
// [RL7] Reg 13h field 00h disables, 3Fh enables port 0; resets to 3Fh.
// [RL8] Reg 14h field 00h disables, 3Fh enables port 1; resets to 0.
// [RL9] Bit7 of each port enable register is register control, resets to 0.
// [RL10] Reg 16h bit2 routes link status to general-purpose pin 3; resets 0.
// [RL11] Reg 16h bit1 routes link status to general-purpose pin 0; resets 1.
// [RL12] Reg 16h bit0 reads back current link status.
// [RL13] Reg 2Eh bits7-6 select virtual channel 0-3; resets to 0.
// [RL14] Software leaves undefined offsets untouched.
// [RL15] Software preserves reserved bits and never relies on them.
`ifndef CSI2_TX_TIMING_DEFS_VH
`define CSI2_TX_TIMING_DEFS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFS_HS_PREPARE 6'h04
`define OFS_HS_ZERO 6'h05
`define OFS_HS_TRAIL 6'h06
`define OFS_HS_EXIT 6'h07
`define OFS_LP_PERIOD 6'h08
`define OFS_RAW_ALIGN 6'h09
`define OFS_PORT0_EN 6'h13
`define OFS_PORT1_EN 6'h14
`define OFS_LINK_ROUTE 6'h16
`define OFS_VC_SELECT 6'h2e

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BIT_OVERRIDE 7
`define BIT_RAW_ALIGN 4
`define BIT_REG_CTRL 7
`define BIT_TO_PIN3 2
`define BIT_TO_PIN0 1
`define BIT_STATUS 0
`define VC_MSB 7
`define VC_LSB 6
`define RST_ZERO 8'h00
`define RST_PORT0_EN 8'h3f
`define RST_LINK_ROUTE 8'h02
`define PORT_FIELD_ON 6'h3f
`define PORT_FIELD_OFF 6'h00
`define REG_COUNT 10

`endif

// *** rtl/csi2_tx_timing_port_ctrl_regs.v ***
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "csi2_tx_timing_defs.vh"
module csi2_tx_timing_port_ctrl_regs #(
   parameter AW = 6
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire clkEn,
   input wire [AW-1:0] addr,
   input wire [7:0] wrData,
   input wire wrStrobe,
   input wire rdStrobe,
   output reg [7:0] rdData,
   input wire linkStatus,
   output wire hsPrepareOverride,
   output wire [4:0] hsPrepare,
   output wire hsZeroOverride,
   output wire [4:0] hsZero,
   output wire hsTrailOverride,
   output wire [3:0] hsTrail,
   output wire hsExitOverride,
   output wire [4:0] hsExit,
   output wire lowPowerPeriodOverride,
   output wire [3:0] lowPowerPeriod,
   output wire rawAlignHigh,
   output wire port0RegisterControl,
   output wire [5:0] port0EnableField,
   output wire port0Enabled,
   output wire port1RegisterControl,
   output wire [5:0] port1EnableField,
   output wire port1Enabled,
   output wire statusToPin3,
   output wire statusToPin0,
   output reg gpio3Out,
   output reg gpio3Sel,
   output reg gpio0Out,
   output reg gpio0Sel,
   output wire [1:0] virtualChannelField
);
   // ----------------------------------------
   // Address decode to store index
   // ----------------------------------------
   reg [3:0] wrIdx;
   reg [3:0] rdIdxC;
   reg rdHit;
   reg wrHit;
   reg rdHitQ;
   reg rdStatusQ;
   reg linkStatusQ;
   wire [79:0] flat;
   wire [7:0] storeData;

   function [4:0] decode;
      input [AW-1:0] a;
      begin
         case (a)
            `OFS_HS_PREPARE: decode = {1'b1, 4'h0};
            `OFS_HS_ZERO: decode = {1'b1, 4'h1};
            `OFS_HS_TRAIL: decode = {1'b1, 4'h2};
            `OFS_HS_EXIT: decode = {1'b1, 4'h3};
            `OFS_LP_PERIOD: decode = {1'b1, 4'h4};
            `OFS_RAW_ALIGN: decode = {1'b1, 4'h5};
            `OFS_PORT0_EN: decode = {1'b1, 4'h6};
            `OFS_PORT1_EN: decode = {1'b1, 4'h7};
            `OFS_LINK_ROUTE: decode = {1'b1, 4'h8};
            `OFS_VC_SELECT: decode = {1'b1, 4'h9};
            default: decode = 5'h00;
         endcase
      end
   endfunction

   always @*
   begin
      {wrHit, wrIdx} = decode(addr);
      {rdHit, rdIdxC} = decode(addr);
   end

   // ----------------------------------------
   // Register words; reserved bits stored as written
   // ----------------------------------------
   // Index 6 resets to 3Fh, index 8 to 02h, rest zero
   localparam [79:0] INIT = {`RST_ZERO, `RST_LINK_ROUTE, `RST_ZERO, `RST_PORT0_EN,
      `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO}; // [RL7] [RL8] [RL9] [RL11]

   // Undefined offsets are ignored on write, read as zero
   reg_store #(
      .WIDTH(8),
      .DEPTH(`REG_COUNT),
      .AW(4),
      .INIT(INIT)
   ) store (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .wrEn(wrStrobe & wrHit), // [RL14]
      .wrIdx(wrIdx),
      .wrData(wrData),
      .rdIdx(rdIdxC),
      .rdData(storeData),
      .flat(flat)
   );

   wire [7:0] regPrep = flat[7:0];
   wire [7:0] regZero = flat[15:8];
   wire [7:0] regTrail = flat[23:16];
   wire [7:0] regExit = flat[31:24];
   wire [7:0] regLp = flat[39:32];
   wire [7:0] regRaw = flat[47:40];
   wire [7:0] regPort0 = flat[55:48];
   wire [7:0] regPort1 = flat[63:56];
   wire [7:0] regRoute = flat[71:64];
   wire [7:0] regVc = flat[79:72];

   // ----------------------------------------
   // Timing overrides toward the transmitter
   // ----------------------------------------
   assign hsPrepareOverride = regPrep[`BIT_OVERRIDE]; // [RL1]
   assign hsPrepare = regPrep[4:0]; // [RL1]
   assign hsZeroOverride = regZero[`BIT_OVERRIDE]; // [RL2]
   assign hsZero = regZero[4:0]; // [RL2]
   assign hsTrailOverride = regTrail[`BIT_OVERRIDE]; // [RL3]
   assign hsTrail = regTrail[3:0]; // [RL3]
   assign hsExitOverride = regExit[`BIT_OVERRIDE]; // [RL4]
   assign hsExit = regExit[4:0]; // [RL4]
   assign lowPowerPeriodOverride = regLp[`BIT_OVERRIDE]; // [RL5]
   assign lowPowerPeriod = regLp[3:0]; // [RL5]

   // ----------------------------------------
   // Pixel alignment, ports, virtual channel
   // ----------------------------------------
   assign rawAlignHigh = regRaw[`BIT_RAW_ALIGN]; // [RL6]
   assign port0RegisterControl = regPort0[`BIT_REG_CTRL]; // [RL9]
   assign port0EnableField = regPort0[5:0];
   // Only the full pattern enables; other codes treated as off
   assign port0Enabled = (regPort0[5:0] == `PORT_FIELD_ON); // [RL7]
   assign port1RegisterControl = regPort1[`BIT_REG_CTRL]; // [RL9]
   assign port1EnableField = regPort1[5:0];
   assign port1Enabled = (regPort1[5:0] == `PORT_FIELD_ON); // [RL8]
   assign virtualChannelField = regVc[`VC_MSB:`VC_LSB]; // [RL13]

   // ----------------------------------------
   // Link status routing
   // ----------------------------------------
   assign statusToPin3 = regRoute[`BIT_TO_PIN3]; // [RL10]
   assign statusToPin0 = regRoute[`BIT_TO_PIN0]; // [RL11]

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         linkStatusQ <= 1'b0;
         gpio3Out <= 1'b0;
         gpio3Sel <= 1'b0;
         gpio0Out <= 1'b0;
         gpio0Sel <= 1'b0;
      end
      else if (clkEn)
      begin
         linkStatusQ <= linkStatus;
         gpio3Out <= statusToPin3 & linkStatus; // [RL10]
         gpio3Sel <= statusToPin3; // [RL10]
         gpio0Out <= statusToPin0 & linkStatus; // [RL11]
         gpio0Sel <= statusToPin0; // [RL11]
      end
   end

   // ----------------------------------------
   // Read path, data one cycle after strobe
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rdHitQ <= 1'b0;
         rdStatusQ <= 1'b0;
      end
      else if (clkEn)
      begin
         rdHitQ <= rdStrobe & rdHit;
         // Status bit is live, stored bit 0 ignored
         rdStatusQ <= rdStrobe & (addr == `OFS_LINK_ROUTE); // [RL12]
      end
   end

   always @*
   begin
      if (!rdHitQ)
         rdData = 8'h00;
      else if (rdStatusQ)
         rdData = {storeData[7:1], linkStatusQ}; // [RL12]
      else
         rdData = storeData;
   end
endmodule

// *** rtl/reg_store.v ***
`timescale 1ns/1ps
// Small register store, one word per index, registered read
module reg_store #(
   parameter WIDTH = 8,
   parameter DEPTH = 10,
   parameter AW = 4,
   parameter [WIDTH*DEPTH-1:0] INIT = 0
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire clkEn,
   input wire wrEn,
   input wire [AW-1:0] wrIdx,
   input wire [WIDTH-1:0] wrData,
   input wire [AW-1:0] rdIdx,
   output reg [WIDTH-1:0] rdData,
   output wire [WIDTH*DEPTH-1:0] flat
);
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1)
      begin : word
         reg [WIDTH-1:0] mem;
         always @(posedge ref_clk)
         begin
            if (!rst_n)
               mem <= INIT[g*WIDTH +: WIDTH];
            else if (clkEn && wrEn && wrIdx == g)
               mem <= wrData;
         end
         assign flat[g*WIDTH +: WIDTH] = mem;
      end
   endgenerate

   always @(posedge ref_clk)
   begin
      if (!rst_n)
         rdData <= {WIDTH{1'b0}};
      else if (clkEn)
         rdData <= (rdIdx < DEPTH) ? flat[rdIdx*WIDTH +: WIDTH] : {WIDTH{1'b0}};
   end
endmodule

// *** testbench/csi2_regs_assertions.sv ***
`timescale 1ns/1ps
// ----------------
// Checker
// ----------------
module csi2_regs_checker #(
   parameter AW = 6
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire clkEn,
   input wire [AW-1:0] addr,
   input wire [7:0] wrData,
   input wire wrStrobe,
   input wire hsPrepareOverride,
   input wire [4:0] hsPrepare,
   input wire hsZeroOverride,
   input wire [4:0] hsZero,
   input wire hsTrailOverride,
   input wire [3:0] hsTrail,
   input wire hsExitOverride,
   input wire [4:0] hsExit,
   input wire lowPowerPeriodOverride,
   input wire [3:0] lowPowerPeriod,
   input wire rawAlignHigh,
   input wire [5:0] port0EnableField,
   input wire port0Enabled,
   input wire [1:0] virtualChannelField
);
   wire wt = wrStrobe & clkEn;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   prep_map_a: assert property (wt && addr == 6'h04 |=>
      {hsPrepareOverride, hsPrepare} == $past({wrData[7], wrData[4:0]})) else $error("prep");
   zero_map_a: assert property (wt && addr == 6'h05 |=>
      {hsZeroOverride, hsZero} == $past({wrData[7], wrData[4:0]})) else $error("zero");
   trail_map_a: assert property (wt && addr == 6'h06 |=>
      {hsTrailOverride, hsTrail} == $past({wrData[7], wrData[3:0]})) else $error("trail");
   exit_map_a: assert property (wt && addr == 6'h07 |=>
      {hsExitOverride, hsExit} == $past({wrData[7], wrData[4:0]})) else $error("exit");
   lp_map_a: assert property (wt && addr == 6'h08 |=>
      {lowPowerPeriodOverride, lowPowerPeriod} == $past({wrData[7], wrData[3:0]})) else $error("lp");
   raw_map_a: assert property (wt && addr == 6'h09 |=>
      rawAlignHigh == $past(wrData[4])) else $error("raw");
   port0_decode_a: assert property (
      port0Enabled == (port0EnableField == 6'h3f)) else $error("port0");
   vc_map_a: assert property (wt && addr == 6'h2e |=>
      virtualChannelField == $past(wrData[7:6])) else $error("vc");
   cover property (wt && addr == 6'h2e);
   cover property (!port0Enabled);
   cover property (rawAlignHigh);
endmodule
bind csi2_tx_timing_port_ctrl_regs csi2_regs_checker #(.AW(AW)) chk (.*);

// *** testbench/link_status_source.sv ***
`timescale 1ns/1ps
// ----------------
// Status source
// ----------------
// Registered, so the level never moves between sampling edges
module link_status_source (
   input wire ref_clk,
   input wire pass,
   output reg linkStatus
);
   initial linkStatus = 1'b0;
   always @(posedge ref_clk) linkStatus <= pass;
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
// ----------------
// Bench
// ----------------
module tb;
   reg ref_clk = 0, rst_n = 0, clkEn = 1, wrStrobe = 0, rdStrobe = 0, pass = 0;
   reg [5:0] addr = 6'h00;
   reg [7:0] wrData = 8'h00;
   wire [7:0] rdData;
   wire [4:0] hsPrepare, hsZero, hsExit;
   wire [3:0] hsTrail, lowPowerPeriod;
   wire [5:0] port0EnableField, port1EnableField;
   wire [1:0] virtualChannelField;
   wire linkStatus, hsPrepareOverride, hsZeroOverride, hsTrailOverride, hsExitOverride, lowPowerPeriodOverride;
   wire rawAlignHigh, port0RegisterControl, port0Enabled, port1RegisterControl, port1Enabled;
   wire statusToPin3, statusToPin0, gpio3Out, gpio3Sel, gpio0Out, gpio0Sel;
   int fails = 0, checks_done = 0, i;
   reg [5:0] ofs [0:9] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h13, 6'h14, 6'h16, 6'h2e};
   reg [7:0] rv [0:9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h02, 8'h00};
   csi2_tx_timing_port_ctrl_regs dut (.*);
   link_status_source src (.ref_clk(ref_clk), .pass(pass), .linkStatus(linkStatus));
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         checks_done++;
         if (seen !== exp)
         begin
            $display("BAD %s exp %h seen %h", nm, exp, seen);
            fails++;
         end
      end
   endtask
   task wr(input [5:0] a, input [7:0] d);
      begin
         @(posedge ref_clk) {addr, wrData, wrStrobe} <= {a, d, 1'b1};
         @(posedge ref_clk) wrStrobe <= 1'b0;
         #1;
      end
   endtask
   task rd(input [5:0] a, input [7:0] e);
      begin
         @(posedge ref_clk) {addr, rdStrobe} <= {a, 1'b1};
         @(posedge ref_clk) rdStrobe <= 1'b0;
         #1 chk("rd", rdData, e);
      end
   endtask
   task results;
      begin
         $display("checks %0d fails %0d", checks_done, fails);
         if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Whole run is under a hundred cycles
   initial
   begin
      #100000;
      fails++;
      results;
   end
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 10; i++) rd(ofs[i], rv[i]);
      chk("route", {4'h0, statusToPin3, statusToPin0, gpio3Sel, gpio0Sel}, 8'h05);
      chk("en", {6'h00, port0Enabled, port1Enabled}, 8'h02);
      for (i = 0; i < 5; i++)
      begin
         wr(ofs[i], 8'h85);
         rd(ofs[i], 8'h85);
      end
      wr(6'h04, 8'h1f);
      chk("prep", {hsPrepareOverride, 2'b00, hsPrepare}, 8'h1f);
      wr(6'h09, 8'h10);
      chk("raw", {7'h00, rawAlignHigh}, 8'h01);
      wr(6'h14, 8'hbf);
      chk("p1", {6'h00, port1RegisterControl, port1Enabled}, 8'h03);
      chk("p1f", {2'b00, port1EnableField}, 8'h3f);
      wr(6'h14, 8'h3e);
      chk("p1", {6'h00, port1RegisterControl, port1Enabled}, 8'h00);
      wr(6'h13, 8'h00);
      chk("p0", {port0RegisterControl, port0EnableField, port0Enabled}, 8'h00);
      @(posedge ref_clk) pass <= 1'b1;
      wr(6'h16, 8'h04);
      repeat (2) @(posedge ref_clk);
      #1 chk("gp", {6'h00, gpio3Out, gpio0Out}, 8'h02);
      chk("route", {4'h0, statusToPin3, statusToPin0, gpio3Sel, gpio0Sel}, 8'h0a);
      rd(6'h16, 8'h05);
      for (i = 0; i < 4; i++)
      begin
         wr(6'h2e, {i[1:0], 6'h00});
         chk("vc", {6'h00, virtualChannelField}, i[7:0]);
      end
      // Unmapped offset must stay silent
      wr(6'h0a, 8'h55);
      rd(6'h0a, 8'h00);
      @(posedge ref_clk) clkEn <= 1'b0;
      wr(6'h09, 8'h00);
      @(posedge ref_clk) clkEn <= 1'b1;
      rd(6'h09, 8'h10);
      results;
   end
endmodule
